// ===== pkg/e1sa_regs.svh
`ifndef E1SA_REGS_SVH
`define E1SA_REGS_SVH

// ------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ------------------------------------------------------------
`define E1SA_SEL_IDX        12'h0130
`define E1SA_ACR1_IDX       12'h0131
`define E1SA_NATDATA_IDX    12'h0134
`define E1SA_STATUS_IDX     12'h013F

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define E1SA_SEL_RST        8'h00
`define E1SA_ACR1_RST       8'h00
`define E1SA_NATDATA_RST    8'h00

// ------------------------------------------------------------
// Field positions: national bit select register
// ------------------------------------------------------------
`define E1SA_SA8_SEL_BIT    7
`define E1SA_SA7_SEL_BIT    6
`define E1SA_SA6_SEL_BIT    5
`define E1SA_SA5_SEL_BIT    4
`define E1SA_SA4_SEL_BIT    3
`define E1SA_LB1_EN_BIT     2
`define E1SA_LB2_EN_BIT     1
`define E1SA_LBR_EN_BIT     0

// ------------------------------------------------------------
// Field positions: auto alarm control register 1
// ------------------------------------------------------------
`define E1SA_OPT1_EN_BIT    7
`define E1SA_SIGLOSS_EN_BIT 6
`define E1SA_OPT2_EN_BIT    5
`define E1SA_OPT3_EN_BIT    4
`define E1SA_OPT4_EN_BIT    3
`define E1SA_ACR1_MASK      8'hF8

// ------------------------------------------------------------
// Field positions: status register
// ------------------------------------------------------------
`define E1SA_ST_LOOP_BIT    0
`define E1SA_ST_LOS_BIT     1
`define E1SA_ST_LFA_BIT     2
`define E1SA_ST_ALARM_BIT   3

// ------------------------------------------------------------
// Timeslot 0 bit positions in a non-alignment frame
// ------------------------------------------------------------
`define E1SA_POS_A          8'h02
`define E1SA_POS_SA4        8'h03
`define E1SA_POS_SA5        8'h04
`define E1SA_POS_SA6        8'h05
`define E1SA_POS_SA8        8'h07

// ------------------------------------------------------------
// Pattern window and patterns
// ------------------------------------------------------------
`define E1SA_WINDOW_FRAMES  4'h8
`define E1SA_PAT_ZERO       8'h00
`define E1SA_PAT_ONES       8'hFF
`define E1SA_PAT_ALT        8'hAA
`define E1SA_SA6_ZERO       4'h0
`define E1SA_SA6_1110       4'hE
`define E1SA_SA6_1100       4'hC

`endif

// ===== pkg/e1sa_pkg.sv
`default_nettype none

package e1sa_pkg;

	// Frame timing from the transmit framing engine
	typedef struct packed {
		logic bitStrobe;
		logic frameStart;
		logic nfasFrame;
	} e1sa_txtime_s;

	// Receive side defect levels
	typedef struct packed {
		logic los;
		logic lfa;
	} e1sa_rxdef_s;

	// Substituted overhead for an alarm option
	typedef struct packed {
		logic       active;
		logic       aKeep;
		logic       aBit;
		logic       sa5;
		logic [3:0] sa6Pat;
	} e1sa_alarm_s;

	// Local loopback state
	typedef enum logic [0:0] {
		E1SA_LOOP_IDLE   = 1'b0,
		E1SA_LOOP_ACTIVE = 1'b1
	} e1sa_loop_e;

endpackage

`default_nettype wire

// ===== rtl/e1sa_bit_history.sv
`include "e1sa_regs.svh"
`default_nettype none

// Eight frame history of one overhead bit, oldest bit in the MSB
module e1sa_bit_history
(
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       sampleEn,
	input  wire logic       sampleBit,
	output logic      [7:0] history,
	output logic            full
);

	logic [3:0] fillCount_reg;

	// ------------------------------------------------------------
	// Shift register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			history <= 8'h00;
		else if (sampleEn)
			history <= {history[6:0], sampleBit};
	end

	// ------------------------------------------------------------
	// Fill count
	// ------------------------------------------------------------
	// Reset contents are all zero, so a match is not trusted until eight real samples
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			fillCount_reg <= 4'h0;
		else if (sampleEn && fillCount_reg != `E1SA_WINDOW_FRAMES)
			fillCount_reg <= fillCount_reg + 4'h1;
	end

	assign full = (fillCount_reg == `E1SA_WINDOW_FRAMES);

endmodule

`default_nettype wire

// ===== rtl/e1sa_ctrl.sv
// Local design decision: the APB interface to the registers.
`include "e1sa_regs.svh"
`default_nettype none

// Overview of operation
// - Enable one: Sa5 zeros, Sa6 ones, A ones for 8 frames enters loopback.
// - Enable two: Sa5 zeros, Sa6 10101010, A ones for 8 frames enters loopback.
// - Release enable: Sa5 and Sa6 zeros for 8 frames leaves loopback.
// - Pattern detection works only while Sa5 and Sa6 come from the pin.
// - Option one on LOS or LFA sends Sa5 one, Sa6 zeros, A untouched.
// - Signal loss option on LOS sends A one, Sa5 one, Sa6 1110.
// - Option two on LOS or LFA sends A one, Sa5 zero, Sa6 zeros.
// - Option three on LOS or LFA sends A zero, Sa5 one, Sa6 1100.
// - Option four on LOS or LFA sends A zero, Sa5 one, Sa6 1110.
// - Option one sends Sa6 as 0000 and leaves A as it came.
// - Per-bit select: 0 takes Sa bit from pin, 1 from register.
module e1sa_ctrl
(
	input  wire logic                  ref_clk,
	input  wire logic                  reset,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic           [11:0] paddr,
	input  wire logic           [31:0] pwdata,
	output logic                [31:0] prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  tx_serial_in,
	input  wire e1sa_pkg::e1sa_txtime_s txTime,
	input  wire e1sa_pkg::e1sa_rxdef_s  rxDefect,
	output logic                       txSerialOut,
	output logic                       localLoopback
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [7:0]                  selReg_reg;
	logic [7:0]                  acrReg_reg;
	logic [7:0]                  natData_reg;
	logic [7:0]                  bitPos_reg;
	logic [7:0]                  curPos;
	logic [1:0]                  sa6Phase_reg;
	logic                        txSerialOut_reg;
	logic [31:0]                 prdata_reg;
	e1sa_pkg::e1sa_loop_e        loop_reg;
	e1sa_pkg::e1sa_loop_e        loop_next;
	e1sa_pkg::e1sa_alarm_s       alarm;
	logic                        inNfas;
	logic                        frameDone;
	logic                        detectArmed;
	logic                        lb1Match;
	logic                        lb2Match;
	logic                        relMatch;
	logic                        outBit;
	logic                        apbAccess;
	logic                        apbWrite;
	logic                        apbRead;
	logic                        addrHit;
	logic [7:0]                  statusByte;
	logic [2:0]                  histEn;
	logic [2:0]                  histFull;
	logic [7:0]                  hist [3];
	logic                        lbrEn;
	logic                        lb1En;
	logic                        lb2En;

	// Register decode, shared by write, read and error paths
	function automatic logic regHit(input logic [11:0] addr, input logic [11:0] idx);
		regHit = (addr == 12'(idx << 2));
	endfunction

	// Either receive defect fires the LOS-or-LFA options
	function automatic logic defectPresent(input e1sa_pkg::e1sa_rxdef_s def);
		defectPresent = def.los || def.lfa;
	endfunction

	// Strobe of one overhead slot in a non-alignment frame
	function automatic logic nfasSlot(input logic [7:0] pos, input logic [7:0] slot, input logic nfasStrobe);
		nfasSlot = nfasStrobe && (pos == slot);
	endfunction

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	// Zero wait states: every access completes in its first access cycle
	assign apbAccess = psel && penable;
	assign apbWrite  = apbAccess && pwrite;
	assign apbRead   = psel && !penable && !pwrite;
	assign addrHit   = regHit(paddr, `E1SA_SEL_IDX) || regHit(paddr, `E1SA_ACR1_IDX)
	                   || regHit(paddr, `E1SA_NATDATA_IDX) || regHit(paddr, `E1SA_STATUS_IDX);
	assign pready    = 1'b1;
	assign pslverr   = apbAccess && !addrHit;
	assign prdata    = prdata_reg;

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	// Writes land at the access edge, where pready is already high
	// Control register writes; unmapped or status writes are dropped
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			selReg_reg  <= `E1SA_SEL_RST;
			acrReg_reg  <= `E1SA_ACR1_RST;
			natData_reg <= `E1SA_NATDATA_RST;
		end
		else if (apbWrite)
		begin
			if (regHit(paddr, `E1SA_SEL_IDX))
				selReg_reg <= pwdata[7:0];
			if (regHit(paddr, `E1SA_ACR1_IDX))
				acrReg_reg <= pwdata[7:0] & `E1SA_ACR1_MASK;
			if (regHit(paddr, `E1SA_NATDATA_IDX))
				natData_reg <= {pwdata[7:3], 3'b000};
		end
	end

	// ------------------------------------------------------------
	// Status and read data
	// ------------------------------------------------------------
	// Status view of loopback and alarm state plus the receive defect inputs
	always_comb
	begin
		statusByte = 8'h00;
		statusByte[`E1SA_ST_LOOP_BIT]  = (loop_reg == e1sa_pkg::E1SA_LOOP_ACTIVE);
		statusByte[`E1SA_ST_LOS_BIT]   = rxDefect.los;
		statusByte[`E1SA_ST_LFA_BIT]   = rxDefect.lfa;
		statusByte[`E1SA_ST_ALARM_BIT] = alarm.active;
	end

	// Read data captured in the setup cycle, stable for the access cycle
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			prdata_reg <= 32'h0000_0000;
		else if (apbRead)
		begin
			if (regHit(paddr, `E1SA_SEL_IDX))
				prdata_reg <= {24'h00_0000, selReg_reg};
			else if (regHit(paddr, `E1SA_ACR1_IDX))
				prdata_reg <= {24'h00_0000, acrReg_reg};
			else if (regHit(paddr, `E1SA_NATDATA_IDX))
				prdata_reg <= {24'h00_0000, natData_reg};
			else if (regHit(paddr, `E1SA_STATUS_IDX))
				prdata_reg <= {24'h00_0000, statusByte};
			else
				prdata_reg <= 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// Frame bit position
	// ------------------------------------------------------------
	// Position of the bit on the pin this cycle; frame start forces zero
	assign curPos = txTime.frameStart ? 8'h00 : bitPos_reg;
	assign inNfas = txTime.bitStrobe && txTime.nfasFrame;

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			bitPos_reg <= 8'h00;
		else if (txTime.bitStrobe)
			bitPos_reg <= curPos + 8'h01;
	end

	// Last overhead bit of a non-alignment frame closes the frame's sample
	assign frameDone = nfasSlot(curPos, `E1SA_POS_SA8, inNfas);

	// Sa6 alarm pattern runs over four successive non-alignment frames
	// Phase runs free; it is not tied to any multiframe boundary
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			sa6Phase_reg <= 2'b00;
		else if (frameDone)
			sa6Phase_reg <= sa6Phase_reg + 2'b01;
	end

	// ------------------------------------------------------------
	// Overhead bit histories (A, Sa5, Sa6)
	// ------------------------------------------------------------
	// Pin bits are sampled always; detection decides whether to trust them
	assign histEn[0] = nfasSlot(curPos, `E1SA_POS_A, inNfas);
	assign histEn[1] = nfasSlot(curPos, `E1SA_POS_SA5, inNfas);
	assign histEn[2] = nfasSlot(curPos, `E1SA_POS_SA6, inNfas);

	// One history per watched overhead bit
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : gHist
			e1sa_bit_history uHist
			(
				.ref_clk   (ref_clk),
				.reset     (reset),
				.sampleEn  (histEn[g]),
				.sampleBit (tx_serial_in),
				.history   (hist[g]),
				.full      (histFull[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Loopback pattern detection
	// ------------------------------------------------------------
	// Activation and release enables from the select register
	assign lb1En = selReg_reg[`E1SA_LB1_EN_BIT];
	assign lb2En = selReg_reg[`E1SA_LB2_EN_BIT];
	assign lbrEn = selReg_reg[`E1SA_LBR_EN_BIT];

	// Register-sourced Sa5/Sa6 never reach the pin, so detection is disarmed
	assign detectArmed = !selReg_reg[`E1SA_SA5_SEL_BIT] && !selReg_reg[`E1SA_SA6_SEL_BIT]
	                     && (&histFull);

	assign lb1Match = lb1En && hist[1] == `E1SA_PAT_ZERO
	                  && hist[2] == `E1SA_PAT_ONES && hist[0] == `E1SA_PAT_ONES;
	assign lb2Match = lb2En && hist[1] == `E1SA_PAT_ZERO
	                  && hist[2] == `E1SA_PAT_ALT && hist[0] == `E1SA_PAT_ONES;
	assign relMatch = lbrEn && hist[1] == `E1SA_PAT_ZERO && hist[2] == `E1SA_PAT_ZERO;

	// ------------------------------------------------------------
	// Loopback state
	// ------------------------------------------------------------
	// Histories are never cleared: a pattern seen before enabling still counts
	// Loopback state decisions: pattern matches once per non-alignment frame, clearing both enables exits at once
	always_comb
	begin
		loop_next = loop_reg;
		case (loop_reg)
			e1sa_pkg::E1SA_LOOP_IDLE:
			begin
				if (frameDone && detectArmed && (lb1Match || lb2Match))
					loop_next = e1sa_pkg::E1SA_LOOP_ACTIVE;
			end
			e1sa_pkg::E1SA_LOOP_ACTIVE:
			begin
				if (!lb1En && !lb2En)
					loop_next = e1sa_pkg::E1SA_LOOP_IDLE;
				else if (frameDone && detectArmed && relMatch)
					loop_next = e1sa_pkg::E1SA_LOOP_IDLE;
			end
			default:
				loop_next = e1sa_pkg::E1SA_LOOP_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			loop_reg <= e1sa_pkg::E1SA_LOOP_IDLE;
		else
			loop_reg <= loop_next;
	end

	// Level only; the data loop itself is built outside this block
	assign localLoopback = (loop_reg == e1sa_pkg::E1SA_LOOP_ACTIVE);

	// ------------------------------------------------------------
	// Automatic alarm pattern selection
	// ------------------------------------------------------------
	// Fixed priority by control bit number; bit 7 outranks the rest
	always_comb
	begin
		alarm = '0;
		// Option one: A bit passes through as it came
		if (acrReg_reg[`E1SA_OPT1_EN_BIT] && defectPresent(rxDefect))
		begin
			alarm.active = 1'b1;
			alarm.aKeep  = 1'b1;
			alarm.sa5    = 1'b1;
			alarm.sa6Pat = `E1SA_SA6_ZERO;
		end
		// Signal loss option ignores loss of frame alignment
		else if (acrReg_reg[`E1SA_SIGLOSS_EN_BIT] && rxDefect.los)
		begin
			alarm.active = 1'b1;
			alarm.aBit   = 1'b1;
			alarm.sa5    = 1'b1;
			alarm.sa6Pat = `E1SA_SA6_1110;
		end
		// Option two: only one that sends Sa5 low
		else if (acrReg_reg[`E1SA_OPT2_EN_BIT] && defectPresent(rxDefect))
		begin
			alarm.active = 1'b1;
			alarm.aBit   = 1'b1;
			alarm.sa5    = 1'b0;
			alarm.sa6Pat = `E1SA_SA6_ZERO;
		end
		// Option three: A low, Sa6 1100
		else if (acrReg_reg[`E1SA_OPT3_EN_BIT] && defectPresent(rxDefect))
		begin
			alarm.active = 1'b1;
			alarm.aBit   = 1'b0;
			alarm.sa5    = 1'b1;
			alarm.sa6Pat = `E1SA_SA6_1100;
		end
		// Option four: lowest priority, A low, Sa6 1110
		else if (acrReg_reg[`E1SA_OPT4_EN_BIT] && defectPresent(rxDefect))
		begin
			alarm.active = 1'b1;
			alarm.aBit   = 1'b0;
			alarm.sa5    = 1'b1;
			alarm.sa6Pat = `E1SA_SA6_1110;
		end
	end

	// ------------------------------------------------------------
	// Outgoing bit insertion
	// ------------------------------------------------------------
	// Alarm overrides Sa5/Sa6, and A except under option one; otherwise each Sa bit follows its select
	always_comb
	begin
		outBit = tx_serial_in;
		if (txTime.nfasFrame)
		begin
			if (curPos == `E1SA_POS_A)
				outBit = (alarm.active && !alarm.aKeep) ? alarm.aBit : tx_serial_in;
			else if (curPos == `E1SA_POS_SA5 && alarm.active)
				outBit = alarm.sa5;
			else if (curPos == `E1SA_POS_SA6 && alarm.active)
				outBit = alarm.sa6Pat[2'd3 - sa6Phase_reg];
			else if (curPos >= `E1SA_POS_SA4 && curPos <= `E1SA_POS_SA8)
				outBit = selReg_reg[curPos[2:0]] ? natData_reg[curPos[2:0]]
				                                 : tx_serial_in;
		end
	end

	// ------------------------------------------------------------
	// Serial output register
	// ------------------------------------------------------------
	// Registered serial output, one clock behind the strobed input bit
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			txSerialOut_reg <= 1'b0;
		else if (txTime.bitStrobe)
			txSerialOut_reg <= outBit;
	end

	// Output port straight from the flip-flop
	assign txSerialOut = txSerialOut_reg;

endmodule

`default_nettype wire

// ===== tb/e1sa_partner.sv
`default_nettype none

// ----------------------------------------
// Backplane source of transmit serial data
// ----------------------------------------
module e1sa_partner
(
	input  wire logic                  ref_clk,
	input  wire logic                  reset,
	input  wire logic            [7:0] aPat,
	input  wire logic            [7:0] sa5Pat,
	input  wire logic            [7:0] sa6Pat,
	output var e1sa_pkg::e1sa_txtime_s txTime,
	output logic                       serialBit
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] pos;
	logic       odd;
	logic [2:0] idx;

	// Bit and frame counters, one E1 bit per clock
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			pos <= 8'h00;
			odd <= 1'b0;
			idx <= 3'h0;
		end
		else
		begin
			pos <= pos + 8'h01;
			if (pos == 8'hFF)
				odd <= !odd;
			if (pos == 8'hFF && odd)
				idx <= idx + 3'h1;
		end
	end

	assign txTime = {!reset, pos == 8'h00, odd};

	// A, Sa5, Sa6 sent on the pin, oldest pattern bit first; other bits toggle
	always_comb
	begin
		serialBit = pos[0];
		if (odd && pos == 8'h02)
			serialBit = aPat[3'h7 - idx];
		if (odd && pos == 8'h04)
			serialBit = sa5Pat[3'h7 - idx];
		if (odd && pos == 8'h05)
			serialBit = sa6Pat[3'h7 - idx];
	end
endmodule

`default_nettype wire

// ===== tb/e1sa_ctrl_monitor.sv
`default_nettype none

// ----------------------------------------
// Port checker
// ----------------------------------------
module e1sa_ctrl_monitor
(
	input wire logic                   ref_clk,
	input wire logic                   reset,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic            [11:0] paddr,
	input wire logic            [31:0] pwdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire e1sa_pkg::e1sa_txtime_s txTime,
	input wire e1sa_pkg::e1sa_rxdef_s  rxDefect,
	input wire logic                   txSerialOut,
	input wire logic                   localLoopback
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] acrSh;
	logic [7:0] posCnt;
	logic [7:0] pos;
	logic       nf;
	logic       wr;
	logic       mapped;
	logic       dfct;

	assign wr = psel && penable && pwrite;
	assign mapped = paddr == 12'h4C0 || paddr == 12'h4C4 || paddr == 12'h4D0 || paddr == 12'h4FC;
	assign pos = txTime.frameStart ? 8'h00 : posCnt;
	assign nf = txTime.bitStrobe && txTime.nfasFrame;
	assign dfct = rxDefect.los || rxDefect.lfa;

	// Shadow of alarm controls, since the checker cannot see the register
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			acrSh <= 8'h00;
		else if (wr && paddr == 12'h4C4)
			acrSh <= pwdata[7:0];
	end

	// Bit position of the current strobe
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			posCnt <= 8'h00;
		else if (txTime.bitStrobe)
			posCnt <= pos + 8'h01;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	chk_ready_high: assert property (pready)
		else $error("pready low");
	chk_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
		else $error("no error on unmapped address");
	chk_err_mapped: assert property (psel && penable && mapped |-> !pslverr)
		else $error("error on mapped address");
	chk_loop_clear: assert property (localLoopback && wr && paddr == 12'h4C0 && pwdata[2:1] == 2'h0 |=> ##1 !localLoopback)
		else $error("loopback held after enables cleared");
	chk_loop_frame: assert property ($rose(localLoopback) |-> $past(nf && pos == 8'h07))
		else $error("loopback rose off a frame end");
	chk_opt1_sa5: assert property (nf && pos == 8'h04 && acrSh[7] && dfct |=> txSerialOut)
		else $error("option one Sa5 wrong");
	chk_sigloss_abit: assert property (nf && pos == 8'h02 && acrSh[7:6] == 2'h1 && rxDefect.los |=> txSerialOut)
		else $error("signal loss A bit wrong");
	chk_opt2_sa5: assert property (nf && pos == 8'h04 && acrSh[7:5] == 3'h1 && dfct |=> !txSerialOut)
		else $error("option two Sa5 wrong");
	chk_opt4_abit: assert property (nf && pos == 8'h02 && acrSh[7:3] == 5'h01 && dfct |=> !txSerialOut)
		else $error("option four A bit wrong");

	cover property ($rose(localLoopback));
	cover property ($fell(localLoopback));
	cover property (pslverr);
endmodule

bind e1sa_ctrl e1sa_ctrl_monitor e1sa_ctrl_monitor_i
(
	.ref_clk       (ref_clk),
	.reset         (reset),
	.psel          (psel),
	.penable       (penable),
	.pwrite        (pwrite),
	.paddr         (paddr),
	.pwdata        (pwdata),
	.pready        (pready),
	.pslverr       (pslverr),
	.txTime        (txTime),
	.rxDefect      (rxDefect),
	.txSerialOut   (txSerialOut),
	.localLoopback (localLoopback)
);

`default_nettype wire

// ===== tb/e1_sa_bit_loopback_alarm_ctrl_bench.sv
`default_nettype none

// ----------------------------------------
// Bench top
// ----------------------------------------
module e1_sa_bit_loopback_alarm_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic                   ref_clk = 1'b0;
	logic                   reset = 1'b1;
	logic                   psel = 1'b0;
	logic                   penable = 1'b0;
	logic                   pwrite = 1'b0;
	logic            [11:0] paddr = 12'h000;
	logic            [31:0] pwdata = 32'h0000_0000;
	logic            [31:0] prdata;
	logic                   pready;
	logic                   pslverr;
	logic                   serialBit;
	e1sa_pkg::e1sa_txtime_s txTime;
	e1sa_pkg::e1sa_rxdef_s  rxDefect = 2'h0;
	logic                   txSerialOut;
	logic                   localLoopback;
	logic             [7:0] aPat = 8'h00;
	logic             [7:0] sa5Pat = 8'h00;
	logic             [7:0] sa6Pat = 8'h00;
	logic            [31:0] rdData;
	logic                   rdErr;
	logic             [7:0] bp = 8'h00;
	logic             [7:0] lastPos = 8'h00;
	logic                   lastNf = 1'b0;
	logic             [3:0] obsA = 4'h0;
	logic             [3:0] obs5 = 4'h0;
	logic             [3:0] obs6 = 4'h0;
	logic            [37:0] tab [11];
	int                     miscompares = 0;
	int                     checkCount = 0;

	always #5 ref_clk = !ref_clk;

	e1sa_ctrl e1sa_ctrl_i (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_serial_in(serialBit), .txTime(txTime), .rxDefect(rxDefect), .txSerialOut(txSerialOut),
		.localLoopback(localLoopback));
	e1sa_partner e1sa_partner_i (.ref_clk(ref_clk), .reset(reset), .aPat(aPat), .sa5Pat(sa5Pat),
		.sa6Pat(sa6Pat), .txTime(txTime), .serialBit(serialBit));

	// Collect A, Sa5, Sa6 as sent, one bit per NFAS frame
	always @(posedge ref_clk)
	begin
		bp <= txTime.frameStart ? 8'h01 : bp + 8'h01;
		lastPos <= txTime.frameStart ? 8'h00 : bp;
		lastNf <= txTime.nfasFrame;
		if (lastNf && lastPos == 8'h02)
			obsA <= {obsA[2:0], txSerialOut};
		if (lastNf && lastPos == 8'h04)
			obs5 <= {obs5[2:0], txSerialOut};
		if (lastNf && lastPos == 8'h05)
			obs6 <= {obs6[2:0], txSerialOut};
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// One APB transfer; waits for pready with a bound
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			$display("BAD pready expected 1 seen %b", pready);
			miscompares++;
			end_sim();
		end
	endtask

	task automatic cmpV(input string nm, input logic [31:0] e, input logic [31:0] g);
		checkCount++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Repeating four-bit pattern, accepted at any phase
	task automatic cmpRot(input string nm, input logic [3:0] e, input logic [3:0] g);
		logic [7:0] d;
		logic [3:0] x;
		d = {e, e};
		x = e;
		for (int i = 0; i < 4; i++)
			if (d[i +: 4] === g)
				x = g;
		cmpV(nm, {28'h0, x}, {28'h0, g});
	endtask

	task automatic waitLoop(input logic v);
		int n;
		n = 0;
		while (localLoopback !== v && n < 6000)
		begin
			@(posedge ref_clk);
			n++;
		end
		cmpV("loopback", {31'h0, v}, {31'h0, localLoopback});
		if (n >= 6000)
			end_sim();
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		// Select, nat data, alarm controls, defects, expected A, Sa5, Sa6
		tab = '{{8'h00, 8'h00, 8'h80, 2'h2, 4'h5, 4'hF, 4'h0}, {8'h00, 8'h00, 8'h40, 2'h2, 4'hF, 4'hF, 4'hE},
			{8'h00, 8'h00, 8'h20, 2'h1, 4'hF, 4'h0, 4'h0}, {8'h00, 8'h00, 8'h10, 2'h2, 4'h0, 4'hF, 4'hC},
			{8'h00, 8'h00, 8'h08, 2'h1, 4'h0, 4'hF, 4'hE}, {8'h00, 8'h00, 8'hF8, 2'h2, 4'h5, 4'hF, 4'h0},
			{8'h00, 8'h00, 8'h58, 2'h1, 4'h0, 4'hF, 4'hC}, {8'h00, 8'h00, 8'hF8, 2'h0, 4'h5, 4'h5, 4'h5},
			{8'h10, 8'h10, 8'h00, 2'h0, 4'h5, 4'hF, 4'h5}, {8'h30, 8'h00, 8'h00, 2'h0, 4'h5, 4'h0, 4'h0},
			{8'h00, 8'h00, 8'h40, 2'h1, 4'h5, 4'h5, 4'h5}};
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		foreach (tab[i])
		begin
			apb(1'b0, (i % 4) == 3 ? 12'h4FC : 12'h4C0 + 12'(i % 4) * 12'h004 + ((i % 4) > 1 ? 12'h008 : 12'h000), 32'h0);
			if (i < 4)
				cmpV("reset value", 32'h0, rdData);
		end
		apb(1'b0, 12'h500, 32'h0);
		cmpV("unmapped error", 32'h1, {31'h0, rdErr});
		apb(1'b1, 12'h4FC, 32'h0000_00FF);
		apb(1'b0, 12'h4FC, 32'h0);
		cmpV("status read only", 32'h0, rdData);
		apb(1'b1, 12'h4C4, 32'h0000_00FF);
		apb(1'b0, 12'h4C4, 32'h0);
		cmpV("alarm ctrl", 32'h0000_00F8, rdData);
		apb(1'b1, 12'h4C4, 32'h0);
		aPat <= 8'hFF;
		sa6Pat <= 8'hAA;
		apb(1'b1, 12'h4C0, 32'h0000_0032);
		repeat (5000) @(posedge ref_clk);
		cmpV("loop from registers", 32'h0, {31'h0, localLoopback});
		apb(1'b1, 12'h4C0, 32'h0000_0002);
		waitLoop(1'b1);
		apb(1'b0, 12'h4FC, 32'h0);
		cmpV("status loop", 32'h1, rdData);
		apb(1'b1, 12'h4C0, 32'h0);
		repeat (2) @(posedge ref_clk);
		cmpV("loop cleared", 32'h0, {31'h0, localLoopback});
		sa6Pat <= 8'hFF;
		apb(1'b1, 12'h4C0, 32'h0000_0004);
		waitLoop(1'b1);
		sa6Pat <= 8'h00;
		apb(1'b1, 12'h4C0, 32'h0000_0005);
		waitLoop(1'b0);
		aPat <= 8'h55;
		sa5Pat <= 8'h55;
		sa6Pat <= 8'h55;
		// Alarm options, priority and per-bit select
		foreach (tab[i])
		begin
			apb(1'b1, 12'h4C0, {24'h0, tab[i][37:30]});
			apb(1'b1, 12'h4D0, {24'h0, tab[i][29:22]});
			apb(1'b1, 12'h4C4, {24'h0, tab[i][21:14]});
			rxDefect <= tab[i][13:12];
			repeat (2560) @(posedge ref_clk);
			cmpRot("A bit", tab[i][11:8], obsA);
			cmpRot("Sa5", tab[i][7:4], obs5);
			cmpRot("Sa6", tab[i][3:0], obs6);
		end
		apb(1'b0, 12'h4FC, 32'h0);
		cmpV("status defects", 32'h0000_0004, rdData);
		end_sim();
	end
endmodule

`default_nettype wire
